// [core/sync_serial_map.svh]
// Register map, field positions and counts of the clocked serial port
// What this block does
// - Either receive enable starts master reception
// - Sample data on falling shift clock
// - Single enable receives one word, then stops
// - Continuous enable keeps receiving until cleared or an overrun
// - Both enables set behaves as continuous
// - Word done sets flag; request if enabled
// - Ninth bit, overrun error in status; byte in buffer
// - Clearing continuous enable clears error state
// - Ninth-bit enable selects nine-bit words
// - Sixteen-bit divisor and width set master rate
// - Polarity bits invert clock and data pins
// - Cleared master select means slave mode
// - Slave shifts on the external pin clock
// - Slave works during any power-managed mode
// - First queued word loads shifter at once
// - Second word waits in transmit buffer
// - Transmit flag clear while buffer holds word
// - Second word loads, then transmit flag sets
// - Transmit flag with enable wakes from sleep
`ifndef SYNC_SERIAL_MAP_SVH
`define SYNC_SERIAL_MAP_SVH

`define SS_OFF_RCV_STAT 8'h00
`define SS_OFF_RCV_BUF 8'h04
`define SS_OFF_XMT_STAT 8'h08
`define SS_OFF_BAUD_CTL 8'h0C
`define SS_OFF_DIV_HI 8'h10
`define SS_OFF_DIV_LO 8'h14
`define SS_OFF_XMT_BUF 8'h18
`define SS_OFF_PER_FLAGS 8'h1C
`define SS_OFF_PER_EN 8'h20
`define SS_OFF_INT_CTL 8'h24
`define SS_OFF_PER_PRIO 8'h28

`define SS_B_PORT_EN 7
`define SS_B_RX9_EN 6
`define SS_B_SINGLE 5
`define SS_B_CONT 4
`define SS_B_FRAME_ERR 2
`define SS_B_OVERRUN 1
`define SS_B_RX_NINTH 0
`define SS_B_MASTER 7
`define SS_B_TX9_EN 6
`define SS_B_TX_EN 5
`define SS_B_CLOCKED 4
`define SS_B_SHIFT_EMPTY 1
`define SS_B_TX_NINTH 0
`define SS_B_DATA_POL 5
`define SS_B_CLK_POL 4
`define SS_B_DIV_WIDE 3
`define SS_B_RX_FLAG 5
`define SS_B_TX_FLAG 4
`define SS_B_GLOBAL_IE 7
`define SS_B_PERIPH_IE 6

`define SS_BITS_SHORT 4'h8
`define SS_BITS_LONG 4'h9
`define SS_RST_BYTE 8'h00
`define SS_RST_DIV 16'h0000
`define SS_RST_BITS 4'h0

`endif

// [core/sync_serial_pkg.sv]
// Types shared by the clocked serial port
package sync_serial_pkg;

  typedef enum logic [1:0] {MCK_IDLE, MCK_LEAD, MCK_TRAIL} mclk_state_e;

  typedef struct packed {
    logic port_enable;
    logic rx9_en;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic overrun_error;
    logic received_ninth_bit;
    logic master_select;
    logic tx9_en;
    logic transmit_enable;
    logic clocked_mode;
    logic transmit_ninth_bit;
    logic data_polarity;
    logic clock_polarity;
    logic divisor_width_select;
    logic [15:0] divisor;
    logic [7:0] rx_buffer;
    logic receive_interrupt_flag;
    logic receive_interrupt_enable;
    logic transmit_interrupt_enable;
    logic global_interrupt_enable;
    logic peripheral_interrupt_enable;
    logic [7:0] priority_bits;
    logic [8:0] tx_buffer;
    logic tx_buffer_full;
    logic [8:0] transmit_shifter;
    logic shifter_busy;
    logic [3:0] tx_count;
    logic [8:0] rx_shift;
    logic [3:0] rx_count;
    logic [15:0] baud_count;
    mclk_state_e mclk_state;
    logic ck_meta;
    logic ck_sync;
    logic ck_prev;
    logic dt_meta;
    logic dt_sync;
  } state_s;

endpackage

// [core/sync_serial_rx_and_slave_tx.sv]
// Clocked serial port: master reception, slave shifting, APB registers
//
// Chosen here: the APB register port and the register offsets.
`include "sync_serial_map.svh"

module sync_serial_rx_and_slave_tx (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Power management
  input wire logic i_sleep,
  output logic o_wake,
  // Interrupt requests
  output logic o_receive_irq,
  output logic o_transmit_irq,
  // Shift timing pin
  input wire logic i_shift_timing_pin,
  output logic o_shift_timing_pin,
  output logic o_shift_timing_pin_oe,
  // Serial line pin
  input wire logic i_serial_line_pin,
  output logic o_serial_line_pin,
  output logic o_serial_line_pin_oe
);

  sync_serial_pkg::state_s st;
  sync_serial_pkg::state_s next_st;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic port_on;
  logic master_on;
  logic slave_on;
  logic tx_on;
  logic rx_on;
  logic baud_tick;
  logic ck_level;
  logic ck_fall;
  logic mck_fall;
  logic sample_now;
  logic din;
  logic [3:0] word_bits;
  logic [8:0] rx_next;
  logic transmit_interrupt_flag;
  logic [15:0] div_eff;

  // Bus qualifiers; zero wait states, so every access phase completes
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & i_penable & ~i_pwrite;
  assign o_pready = 1'b1;

  always_comb begin
    case (i_paddr)
      `SS_OFF_RCV_STAT,
      `SS_OFF_RCV_BUF,
      `SS_OFF_XMT_STAT,
      `SS_OFF_BAUD_CTL,
      `SS_OFF_DIV_HI,
      `SS_OFF_DIV_LO,
      `SS_OFF_XMT_BUF,
      `SS_OFF_PER_FLAGS,
      `SS_OFF_PER_EN,
      `SS_OFF_INT_CTL,
      `SS_OFF_PER_PRIO: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign o_pslverr = i_psel & i_penable & ~addr_ok;

  // Operating modes
  assign port_on = st.port_enable & st.clocked_mode;
  assign master_on = port_on & st.master_select;
  assign slave_on = port_on & ~st.master_select;
  assign tx_on = slave_on & st.transmit_enable;
  // Continuous enable alone suffices; single counts only for a master
  assign rx_on = port_on & ~st.overrun_error
               & (st.continuous_receive_enable
                  | (st.single_receive_enable & st.master_select));

  assign word_bits = st.rx9_en ? `SS_BITS_LONG : `SS_BITS_SHORT;

  // Master timing comes from the core clock, so it halts while asleep
  assign div_eff = st.divisor_width_select ? st.divisor
                                           : {8'h00, st.divisor[7:0]};
  assign baud_tick = master_on & ~i_sleep & (st.baud_count == `SS_RST_DIV);

  // Pin clock is polarity-corrected after the synchroniser
  assign ck_level = st.ck_sync ^ st.clock_polarity;
  assign ck_fall = slave_on & st.ck_prev & ~ck_level;
  assign mck_fall = baud_tick & (st.mclk_state == sync_serial_pkg::MCK_LEAD);
  assign sample_now = st.master_select ? mck_fall : ck_fall;
  assign din = st.dt_sync ^ st.data_polarity;
  assign rx_next = {din, st.rx_shift[8:1]};

  assign transmit_interrupt_flag = ~st.tx_buffer_full;

  always_comb begin
    next_st = st;

    // Two-flop synchronisers; only the second stage feeds logic
    next_st.ck_meta = i_shift_timing_pin;
    next_st.ck_sync = st.ck_meta;
    next_st.ck_prev = ck_level;
    next_st.dt_meta = i_serial_line_pin;
    next_st.dt_sync = st.dt_meta;

    // Register writes
    if (wr_en) begin
      case (i_paddr)
        `SS_OFF_RCV_STAT: begin
          next_st.port_enable = i_pwdata[`SS_B_PORT_EN];
          next_st.rx9_en = i_pwdata[`SS_B_RX9_EN];
          next_st.single_receive_enable = i_pwdata[`SS_B_SINGLE];
          next_st.continuous_receive_enable = i_pwdata[`SS_B_CONT];
        end
        `SS_OFF_XMT_STAT: begin
          next_st.master_select = i_pwdata[`SS_B_MASTER];
          next_st.tx9_en = i_pwdata[`SS_B_TX9_EN];
          next_st.transmit_enable = i_pwdata[`SS_B_TX_EN];
          next_st.clocked_mode = i_pwdata[`SS_B_CLOCKED];
          next_st.transmit_ninth_bit = i_pwdata[`SS_B_TX_NINTH];
        end
        `SS_OFF_BAUD_CTL: begin
          next_st.data_polarity = i_pwdata[`SS_B_DATA_POL];
          next_st.clock_polarity = i_pwdata[`SS_B_CLK_POL];
          next_st.divisor_width_select = i_pwdata[`SS_B_DIV_WIDE];
        end
        `SS_OFF_DIV_HI: next_st.divisor[15:8] = i_pwdata[7:0];
        `SS_OFF_DIV_LO: next_st.divisor[7:0] = i_pwdata[7:0];
        `SS_OFF_XMT_BUF: begin
          // Ninth bit is taken with the byte, so it must be written first
          next_st.tx_buffer = {st.transmit_ninth_bit, i_pwdata[7:0]};
          next_st.tx_buffer_full = 1'b1;
        end
        `SS_OFF_PER_EN: begin
          next_st.receive_interrupt_enable = i_pwdata[`SS_B_RX_FLAG];
          next_st.transmit_interrupt_enable = i_pwdata[`SS_B_TX_FLAG];
        end
        `SS_OFF_INT_CTL: begin
          next_st.global_interrupt_enable = i_pwdata[`SS_B_GLOBAL_IE];
          next_st.peripheral_interrupt_enable = i_pwdata[`SS_B_PERIPH_IE];
        end
        `SS_OFF_PER_PRIO: next_st.priority_bits = i_pwdata[7:0];
        default: begin
        end
      endcase
    end

    // Reading the received byte releases the flag; a new word wins below
    if (rd_en && i_paddr == `SS_OFF_RCV_BUF) begin
      next_st.receive_interrupt_flag = 1'b0;
    end

    // Dropping continuous reception clears errors; dropping both enables clears any partial word
    if (!next_st.continuous_receive_enable) begin
      next_st.overrun_error = 1'b0;
    end
    if (!next_st.continuous_receive_enable && !next_st.single_receive_enable) begin
      next_st.rx_count = `SS_RST_BITS;
    end

    // Baud generator: reload on each tick
    if (!master_on) begin
      next_st.baud_count = div_eff;
    end else if (!i_sleep) begin
      if (baud_tick) begin
        next_st.baud_count = div_eff;
      end else begin
        next_st.baud_count = st.baud_count - 16'h0001;
      end
    end

    // Master clock: one lead and one trail half-period per bit
    case (st.mclk_state)
      sync_serial_pkg::MCK_IDLE: begin
        if (baud_tick && rx_on) begin
          next_st.mclk_state = sync_serial_pkg::MCK_LEAD;
        end
      end
      sync_serial_pkg::MCK_LEAD: begin
        if (!master_on) begin
          next_st.mclk_state = sync_serial_pkg::MCK_IDLE;
        end else if (baud_tick) begin
          next_st.mclk_state = sync_serial_pkg::MCK_TRAIL;
        end
      end
      sync_serial_pkg::MCK_TRAIL: begin
        if (!master_on) begin
          next_st.mclk_state = sync_serial_pkg::MCK_IDLE;
        end else if (baud_tick) begin
          // rx_on already reflects a finished single word
          if (rx_on) begin
            next_st.mclk_state = sync_serial_pkg::MCK_LEAD;
          end else begin
            next_st.mclk_state = sync_serial_pkg::MCK_IDLE;
          end
        end
      end
      default: next_st.mclk_state = sync_serial_pkg::MCK_IDLE;
    endcase

    // Reception; half-duplex, so a busy slave shifter blocks it
    if (rx_on && sample_now && !(tx_on && st.shifter_busy)) begin
      next_st.rx_shift = rx_next;
      if (st.rx_count == word_bits - 4'h1) begin
        next_st.rx_count = `SS_RST_BITS;
        if (st.receive_interrupt_flag &&
            !(rd_en && i_paddr == `SS_OFF_RCV_BUF)) begin
          // Unread byte is kept; new word is lost
          next_st.overrun_error = 1'b1;
        end else begin
          if (st.rx9_en) begin
            next_st.rx_buffer = rx_next[7:0];
            next_st.received_ninth_bit = rx_next[8];
          end else begin
            next_st.rx_buffer = rx_next[8:1];
            next_st.received_ninth_bit = 1'b0;
          end
          next_st.receive_interrupt_flag = 1'b1;
        end
        if (!st.continuous_receive_enable) begin
          next_st.single_receive_enable = 1'b0;
        end
      end else begin
        next_st.rx_count = st.rx_count + 4'h1;
      end
    end

    // Slave transmit shifter
    if (!tx_on) begin
      next_st.shifter_busy = 1'b0;
      next_st.tx_count = `SS_RST_BITS;
    end else if (st.shifter_busy) begin
      if (ck_fall) begin
        next_st.transmit_shifter = {1'b0, st.transmit_shifter[8:1]};
        if (st.tx_count == (st.tx9_en ? `SS_BITS_LONG : `SS_BITS_SHORT) - 4'h1) begin
          next_st.shifter_busy = 1'b0;
          next_st.tx_count = `SS_RST_BITS;
        end else begin
          next_st.tx_count = st.tx_count + 4'h1;
        end
      end
    end else if (st.tx_buffer_full) begin
      // Loading empties the buffer, which raises the transmit flag
      next_st.transmit_shifter = st.tx_buffer;
      next_st.shifter_busy = 1'b1;
      next_st.tx_count = `SS_RST_BITS;
      if (!(wr_en && i_paddr == `SS_OFF_XMT_BUF)) begin
        next_st.tx_buffer_full = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
      st.mclk_state <= sync_serial_pkg::MCK_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Register reads; unmapped addresses return zero
  always_comb begin
    o_prdata = 32'h0000_0000;
    case (i_paddr)
      `SS_OFF_RCV_STAT: begin
        o_prdata[`SS_B_PORT_EN] = st.port_enable;
        o_prdata[`SS_B_RX9_EN] = st.rx9_en;
        o_prdata[`SS_B_SINGLE] = st.single_receive_enable;
        o_prdata[`SS_B_CONT] = st.continuous_receive_enable;
        o_prdata[`SS_B_OVERRUN] = st.overrun_error;
        o_prdata[`SS_B_RX_NINTH] = st.received_ninth_bit;
      end
      `SS_OFF_RCV_BUF: o_prdata[7:0] = st.rx_buffer;
      `SS_OFF_XMT_STAT: begin
        o_prdata[`SS_B_MASTER] = st.master_select;
        o_prdata[`SS_B_TX9_EN] = st.tx9_en;
        o_prdata[`SS_B_TX_EN] = st.transmit_enable;
        o_prdata[`SS_B_CLOCKED] = st.clocked_mode;
        o_prdata[`SS_B_SHIFT_EMPTY] = ~st.shifter_busy;
        o_prdata[`SS_B_TX_NINTH] = st.transmit_ninth_bit;
      end
      `SS_OFF_BAUD_CTL: begin
        o_prdata[`SS_B_DATA_POL] = st.data_polarity;
        o_prdata[`SS_B_CLK_POL] = st.clock_polarity;
        o_prdata[`SS_B_DIV_WIDE] = st.divisor_width_select;
      end
      `SS_OFF_DIV_HI: o_prdata[7:0] = st.divisor[15:8];
      `SS_OFF_DIV_LO: o_prdata[7:0] = st.divisor[7:0];
      `SS_OFF_XMT_BUF: o_prdata[7:0] = st.tx_buffer[7:0];
      `SS_OFF_PER_FLAGS: begin
        o_prdata[`SS_B_RX_FLAG] = st.receive_interrupt_flag;
        o_prdata[`SS_B_TX_FLAG] = transmit_interrupt_flag;
      end
      `SS_OFF_PER_EN: begin
        o_prdata[`SS_B_RX_FLAG] = st.receive_interrupt_enable;
        o_prdata[`SS_B_TX_FLAG] = st.transmit_interrupt_enable;
      end
      `SS_OFF_INT_CTL: begin
        o_prdata[`SS_B_GLOBAL_IE] = st.global_interrupt_enable;
        o_prdata[`SS_B_PERIPH_IE] = st.peripheral_interrupt_enable;
      end
      `SS_OFF_PER_PRIO: o_prdata[7:0] = st.priority_bits;
      default: o_prdata = 32'h0000_0000;
    endcase
  end

  // Requests ignore the global enables; those only gate vectoring
  assign o_receive_irq = st.receive_interrupt_flag & st.receive_interrupt_enable;
  assign o_transmit_irq = transmit_interrupt_flag & st.transmit_interrupt_enable;
  assign o_wake = i_sleep & (o_receive_irq | o_transmit_irq);

  // Pins
  assign o_shift_timing_pin_oe = master_on;
  assign o_shift_timing_pin = (st.mclk_state == sync_serial_pkg::MCK_LEAD)
                              ^ st.clock_polarity;
  assign o_serial_line_pin_oe = tx_on & st.shifter_busy;
  assign o_serial_line_pin = st.transmit_shifter[0] ^ st.data_polarity;

endmodule // sync_serial_rx_and_slave_tx

// [tb/sync_serial_rx_and_slave_tx_props.sv]
// Concurrent checks on the serial port's bus, request and pin outputs
module sync_serial_rx_and_slave_tx_props (
  // Clock, reset, bus
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Power and requests
  input wire logic i_sleep,
  input wire logic o_wake,
  input wire logic o_receive_irq,
  input wire logic o_transmit_irq,
  // Pins
  input wire logic i_shift_timing_pin,
  input wire logic o_shift_timing_pin,
  input wire logic o_shift_timing_pin_oe,
  input wire logic o_serial_line_pin,
  input wire logic o_serial_line_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic [3:0] since_ck;
  logic ck_prev;
  // Saturates so a stopped pin clock never wraps back to a small count
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      since_ck <= 4'hF;
      ck_prev <= 1'b0;
    end else begin
      ck_prev <= i_shift_timing_pin;
      since_ck <= (i_shift_timing_pin != ck_prev) ? 4'h0 : since_ck + {3'h0, since_ck != 4'hF};
    end
  end
  property p_ready;
    i_psel && i_penable |-> o_pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_unmapped;
    i_psel && i_penable && i_paddr > 8'h28 |-> o_pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_err_quiet;
    !i_penable |-> !o_pslverr;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error outside access");
  property p_wake_cause;
    o_wake |-> i_sleep && (o_receive_irq || o_transmit_irq);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without request");
  property p_wake_need;
    i_sleep && (o_receive_irq || o_transmit_irq) |-> o_wake;
  endproperty
  a_wake_need: assert property (p_wake_need) else $error("request did not wake");
  property p_half_duplex;
    o_shift_timing_pin_oe |-> !o_serial_line_pin_oe;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("master drives data pin");
  property p_slave_shift;
    o_serial_line_pin_oe && $past(o_serial_line_pin_oe) && $changed(o_serial_line_pin)
      && !$past(i_psel) |-> since_ck <= 4'h8;
  endproperty
  a_slave_shift: assert property (p_slave_shift) else $error("shift without pin clock");
  property p_clk_still;
    !o_shift_timing_pin_oe && !$past(o_shift_timing_pin_oe) && !$past(o_shift_timing_pin_oe, 2)
      && !$past(i_psel) && !$past(i_psel, 2) |-> $stable(o_shift_timing_pin);
  endproperty
  a_clk_still: assert property (p_clk_still) else $error("clock moved outside master");
  c_rx: cover property ($rose(o_receive_irq));
  c_wake: cover property ($rose(o_wake));
  c_slave_tx: cover property ($rose(o_serial_line_pin_oe));
endmodule // sync_serial_rx_and_slave_tx_props

bind sync_serial_rx_and_slave_tx sync_serial_rx_and_slave_tx_props props_i (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sleep(i_sleep),
  .o_wake(o_wake), .o_receive_irq(o_receive_irq), .o_transmit_irq(o_transmit_irq),
  .i_shift_timing_pin(i_shift_timing_pin), .o_shift_timing_pin(o_shift_timing_pin),
  .o_shift_timing_pin_oe(o_shift_timing_pin_oe), .o_serial_line_pin(o_serial_line_pin),
  .o_serial_line_pin_oe(o_serial_line_pin_oe));

// [tb/sync_serial_peer.sv]
// Behavioural far-side peer on the shift clock and data pins
module sync_serial_peer (
  // Core clock for edge detection
  input wire logic i_mclk,
  // Pin levels and clock polarity
  input wire logic i_ck,
  input wire logic i_dt,
  input wire logic i_ck_pol,
  // Peer drive
  output logic o_ck,
  output logic o_dt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] tx = 64'h0;
  int left = 0;
  logic idle = 1'b1;
  logic ck_gen = 1'b0;
  logic prev = 1'b0;
  logic [8:0] got = 9'h000;
  // Outside frames the clock rests at its idle level
  assign o_ck = ck_gen ^ i_ck_pol;
  initial o_dt = 1'b0;
  // Next bit leaves on the leading edge so it is steady at the sampling edge
  always @(posedge i_mclk) begin
    prev <= i_ck ^ i_ck_pol;
    if ((i_ck ^ i_ck_pol) && !prev && left > 0) begin
      o_dt <= tx[0];
      tx <= tx >> 1;
      left <= left - 1;
      idle <= 1'b0;
    end else if (!(i_ck ^ i_ck_pol) && prev && left == 0) begin
      idle <= 1'b1;
    end else if (idle) begin
      o_dt <= ~o_dt;
    end
  end
  task automatic load(input logic [8:0] w, input int n);
    tx = tx | (64'(w) << left);
    left = left + n;
  endtask
  task automatic clock_word(input int n);
    for (int k = 0; k < n; k++) begin
      #80 ck_gen = 1'b1;
      #80 got = {i_dt, got[8:1]};
      ck_gen = 1'b0;
    end
  endtask
endmodule // sync_serial_peer

// [tb/sync_serial_rx_and_slave_tx_tb_top.sv]
// Self-checking bench for the clocked serial port
`include "sync_serial_map.svh"
module sync_serial_rx_and_slave_tx_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleep = 1'b0;
  logic ck_pol = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, wake, rx_irq, tx_irq;
  logic ck_o, ck_oe, dt_o, dt_oe, peer_ck, peer_dt, ck_w, dt_w;
  int error_cnt = 0;
  int num_checks = 0;
  int n;
  always #10 i_mclk = ~i_mclk;
  assign ck_w = ck_oe ? ck_o : peer_ck;
  assign dt_w = dt_oe ? dt_o : peer_dt;
  sync_serial_rx_and_slave_tx sync_serial_rx_and_slave_tx_i (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sleep(sleep), .o_wake(wake),
    .o_receive_irq(rx_irq), .o_transmit_irq(tx_irq), .i_shift_timing_pin(ck_w),
    .o_shift_timing_pin(ck_o), .o_shift_timing_pin_oe(ck_oe), .i_serial_line_pin(dt_w),
    .o_serial_line_pin(dt_o), .o_serial_line_pin_oe(dt_oe));
  sync_serial_peer sync_serial_peer_i (.i_mclk(i_mclk), .i_ck(ck_w), .i_dt(dt_w),
    .i_ck_pol(ck_pol), .o_ck(peer_ck), .o_dt(peer_dt));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Answer is taken at the falling edge, where it is settled for the rising edge that ends access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    @(posedge i_mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      @(negedge i_mclk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      @(posedge i_mclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Bounded wait for a request line; the bound covers the slowest divisor used
  task automatic wait_irq(input logic tx);
    for (int i = 0; i < 6000 && (tx ? tx_irq : rx_irq) !== 1'b1; i++) @(posedge i_mclk);
  endtask
  // Cycles between two successive moves of the master clock pin
  task automatic gap(output int c);
    for (int k = 0; k < 2; k++) begin
      logic last;
      last = ck_o;
      c = 0;
      while (ck_o === last && c < 2000) begin
        @(negedge i_mclk);
        c++;
      end
    end
  endtask
  task automatic t_reset_regs;
    rdc(`SS_OFF_RCV_STAT, 32'h0);
    rdc(`SS_OFF_XMT_STAT, 32'h2);
    rdc(`SS_OFF_PER_FLAGS, 32'h10);
    rdc(8'h2C, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask
  task automatic t_master_single;
    ck_pol <= 1'b1;
    wr(`SS_OFF_BAUD_CTL, 32'h30);
    wr(`SS_OFF_DIV_HI, 32'h01);
    wr(`SS_OFF_DIV_LO, 32'h04);
    wr(`SS_OFF_PER_EN, 32'h20);
    wr(`SS_OFF_XMT_STAT, 32'h90);
    wr(`SS_OFF_RCV_STAT, 32'h80);
    check({31'h0, ck_o}, 32'h1);
    sync_serial_peer_i.load(9'h0C3, 8);
    wr(`SS_OFF_RCV_STAT, 32'hA0);
    gap(n);
    check(n, 32'h5);
    wait_irq(1'b0);
    check({31'h0, rx_irq}, 32'h1);
    rdc(`SS_OFF_RCV_STAT, 32'h80);
    rdc(`SS_OFF_RCV_BUF, 32'h3C);
    repeat (40) @(posedge i_mclk);
    check({30'h0, rx_irq, ck_o}, 32'h1);
  endtask
  task automatic t_master_cont;
    ck_pol <= 1'b0;
    wr(`SS_OFF_BAUD_CTL, 32'h08);
    sync_serial_peer_i.load(9'h1A5, 9);
    sync_serial_peer_i.load(9'h05A, 9);
    sync_serial_peer_i.load(9'h133, 9);
    wr(`SS_OFF_RCV_STAT, 32'hF0);
    gap(n);
    check(n, 32'd261);
    wait_irq(1'b0);
    apb(1'b0, `SS_OFF_RCV_STAT, 32'h0);
    check(rd & 32'hDF, 32'hD1);
    rdc(`SS_OFF_RCV_BUF, 32'hA5);
    for (int i = 0; i < 4000 && rd[1] !== 1'b1; i++) apb(1'b0, `SS_OFF_RCV_STAT, 32'h0);
    check(rd & 32'hDF, 32'hD2);
    rdc(`SS_OFF_RCV_BUF, 32'h5A);
    wr(`SS_OFF_RCV_STAT, 32'hC0);
    rdc(`SS_OFF_RCV_STAT, 32'hC0);
  endtask
  task automatic t_slave_tx_sleep;
    wr(`SS_OFF_BAUD_CTL, 32'h00);
    wr(`SS_OFF_RCV_STAT, 32'h80);
    wr(`SS_OFF_XMT_STAT, 32'h71);
    wr(`SS_OFF_PER_EN, 32'h10);
    wr(`SS_OFF_XMT_BUF, 32'h96);
    wr(`SS_OFF_XMT_BUF, 32'h3C);
    sleep <= 1'b1;
    check({30'h0, ck_oe, dt_oe}, 32'h1);
    rdc(`SS_OFF_PER_FLAGS, 32'h00);
    check({31'h0, wake}, 32'h0);
    sync_serial_peer_i.clock_word(9);
    check({23'h0, sync_serial_peer_i.got}, 32'h196);
    wait_irq(1'b1);
    check({31'h0, wake}, 32'h1);
    rdc(`SS_OFF_PER_FLAGS, 32'h10);
    sync_serial_peer_i.clock_word(9);
    check({23'h0, sync_serial_peer_i.got}, 32'h13C);
    sleep <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_mclk);
    i_resetn <= 1'b1;
    t_reset_regs;
    t_master_single;
    t_master_cont;
    t_slave_tx_sleep;
    final_report;
  end
  initial begin
    #2000000;
    error_cnt++;
    final_report;
  end
endmodule // sync_serial_rx_and_slave_tx_tb_top
